// [pfb_pkg.sv]
// shared constants and types for the programmable-flag buffer
package pfb_pkg;
   localparam int DATA_W = 9;
   localparam int OFS_W = 8;
   localparam int DEPTH = 64;
   localparam int PTR_W = 6;
   localparam int CNT_W = 7;
   localparam int THR_W = 17;
   localparam logic [CNT_W-1:0] DEPTH_CNT = 7'h40;
   localparam logic [OFS_W-1:0] EMPTY_OFS_LOW_RST = 8'h07;
   localparam logic [OFS_W-1:0] EMPTY_OFS_HIGH_RST = 8'h00;
   localparam logic [OFS_W-1:0] FULL_OFS_LOW_RST = 8'h07;
   localparam logic [OFS_W-1:0] FULL_OFS_HIGH_RST = 8'h00;
   localparam logic [DATA_W-1:0] READ_DATA_RST = 9'h000;
   localparam real RESET_TO_FLAG_NS = 18.0;
   localparam real CLK_PERIOD_NS = 8.0;
   localparam int RESET_TO_FLAG_CYC = (RESET_TO_FLAG_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
      int'(RESET_TO_FLAG_NS / CLK_PERIOD_NS - 0.5);

   typedef enum logic [1:0] {
      PFB_SEL_EMPTY_LOW,
      PFB_SEL_EMPTY_HIGH,
      PFB_SEL_FULL_LOW,
      PFB_SEL_FULL_HIGH
   } pfb_sel_t;

   typedef struct packed {
      logic full_flag_n;
      logic almost_full_flag_n;
      logic almost_empty_flag_n;
      logic empty_flag_n;
   } pfb_flags_t;

   // empty and almost-empty low, full and almost-full high
   localparam pfb_flags_t FLAGS_RST = 4'b1100;
endpackage

// [pfb_store.sv]
// flip-flop storage array with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pfb_store #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 64,
   parameter int PTR_W = 6,
   parameter int CNT_W = 7
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data,
   output logic [CNT_W-1:0] o_count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [PTR_W-1:0] next_wr_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [CNT_W-1:0] next_count;
   logic wr_fire;
   logic rd_fire;

   always_comb begin
      o_wr_ready = (count != CNT_W'(DEPTH));
      o_rd_valid = (count != '0);
      o_rd_data = mem[rd_ptr];
      o_count = count;
      wr_fire = i_wr_valid && o_wr_ready;
      rd_fire = i_rd_ready && o_rd_valid;
      next_wr_ptr = wr_fire ? wr_ptr + PTR_W'(1) : wr_ptr;
      next_rd_ptr = rd_fire ? rd_ptr + PTR_W'(1) : rd_ptr;
      next_count = count + CNT_W'(wr_fire) - CNT_W'(rd_fire);
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // contents need no reset; only the count defines emptiness
   for (genvar e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge i_clk_sys) begin
         if (wr_fire && wr_ptr == PTR_W'(e)) begin
            mem[e] <= i_wr_data;
         end
      end
   end
endmodule
`default_nettype wire

// [pfb_top.sv]
// single-clock nine-bit buffer with programmable almost flags
`timescale 1ns/1ps
`default_nettype none
module pfb_top
   import pfb_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [DATA_W-1:0] i_write_data_bus,
   input wire logic i_write_enable_primary_n,
   input wire logic i_write_enable_secondary_or_load,
   input wire logic i_read_enable_a_n,
   input wire logic i_read_enable_b_n,
   input wire logic i_output_enable_n,
   output logic [DATA_W-1:0] o_read_data_bus,
   output logic o_read_data_oe,
   output pfb_flags_t o_flags
);
   // strap capture state
   logic strap_pending;
   logic flag_mode;
   logic next_strap_pending;
   logic next_flag_mode;

   // offset registers and rotation position
   logic [OFS_W-1:0] empty_offset_low;
   logic [OFS_W-1:0] empty_offset_high;
   logic [OFS_W-1:0] full_offset_low;
   logic [OFS_W-1:0] full_offset_high;
   pfb_sel_t ofs_sel;
   logic [OFS_W-1:0] next_empty_offset_low;
   logic [OFS_W-1:0] next_empty_offset_high;
   logic [OFS_W-1:0] next_full_offset_low;
   logic [OFS_W-1:0] next_full_offset_high;
   pfb_sel_t next_ofs_sel;

   // output side
   logic [DATA_W-1:0] read_data;
   logic read_oe;
   pfb_flags_t flags;
   logic [DATA_W-1:0] next_read_data;
   logic next_read_oe;
   pfb_flags_t next_flags;

   // decode and storage handshake
   logic load_active;
   logic wr_req;
   logic rd_req;
   logic ofs_wr;
   logic ofs_rd;
   logic st_wr_ready;
   logic st_rd_valid;
   logic [DATA_W-1:0] st_rd_data;
   logic [CNT_W-1:0] st_count;
   logic [CNT_W-1:0] next_count;
   logic [THR_W-1:0] empty_n_thr;
   logic [THR_W-1:0] full_m_thr;
   logic [OFS_W-1:0] ofs_value;

   pfb_store #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH),
      .PTR_W(PTR_W),
      .CNT_W(CNT_W)
   ) pfb_store_inst (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_wr_valid(wr_req),
      .o_wr_ready(st_wr_ready),
      .i_wr_data(i_write_data_bus),
      .o_rd_valid(st_rd_valid),
      .i_rd_ready(rd_req),
      .o_rd_data(st_rd_data),
      .o_count(st_count)
   );

   // mode strap sampled on first edge after release
   always_comb begin
      next_strap_pending = 1'b0;
      next_flag_mode = strap_pending ? !i_write_enable_secondary_or_load : flag_mode;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         strap_pending <= 1'b1;
         flag_mode <= 1'b0;
      end else begin
         strap_pending <= next_strap_pending;
         flag_mode <= next_flag_mode;
      end
   end

   always_comb begin
      load_active = flag_mode && !i_write_enable_secondary_or_load;
      // write gating per mode; transfers held off during strap capture
      wr_req = !strap_pending && !i_write_enable_primary_n &&
         (flag_mode ? 1'b1 : i_write_enable_secondary_or_load) && !load_active;
      // both read enables low take the next entry
      rd_req = !strap_pending && !i_read_enable_a_n && !i_read_enable_b_n && !load_active;
      // offset write when load and primary enable both low
      ofs_wr = !strap_pending && load_active && !i_write_enable_primary_n;
      // offset read when load and both read enables low
      ofs_rd = !strap_pending && load_active && !i_read_enable_a_n && !i_read_enable_b_n;
   end

   always_comb begin
      next_empty_offset_low = empty_offset_low;
      next_empty_offset_high = empty_offset_high;
      next_full_offset_low = full_offset_low;
      next_full_offset_high = full_offset_high;
      next_ofs_sel = ofs_sel;
      case (ofs_sel)
         PFB_SEL_EMPTY_LOW: ofs_value = empty_offset_low;
         PFB_SEL_EMPTY_HIGH: ofs_value = empty_offset_high;
         PFB_SEL_FULL_LOW: ofs_value = full_offset_low;
         PFB_SEL_FULL_HIGH: ofs_value = full_offset_high;
         default: ofs_value = empty_offset_low;
      endcase
      if (ofs_wr) begin
         case (ofs_sel)
            PFB_SEL_EMPTY_LOW: next_empty_offset_low = i_write_data_bus[OFS_W-1:0];
            PFB_SEL_EMPTY_HIGH: next_empty_offset_high = i_write_data_bus[OFS_W-1:0];
            PFB_SEL_FULL_LOW: next_full_offset_low = i_write_data_bus[OFS_W-1:0];
            PFB_SEL_FULL_HIGH: next_full_offset_high = i_write_data_bus[OFS_W-1:0];
            default: next_empty_offset_low = empty_offset_low;
         endcase
      end
      // simultaneous write and read advance once; not protected further
      // position survives load release, wraps after the fourth
      if (ofs_wr || ofs_rd) begin
         next_ofs_sel = pfb_sel_t'(ofs_sel + 2'h1);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         empty_offset_low <= EMPTY_OFS_LOW_RST;
         empty_offset_high <= EMPTY_OFS_HIGH_RST;
         full_offset_low <= FULL_OFS_LOW_RST;
         full_offset_high <= FULL_OFS_HIGH_RST;
         ofs_sel <= PFB_SEL_EMPTY_LOW;
      end else begin
         empty_offset_low <= next_empty_offset_low;
         empty_offset_high <= next_empty_offset_high;
         full_offset_low <= next_full_offset_low;
         full_offset_high <= next_full_offset_high;
         ofs_sel <= next_ofs_sel;
      end
   end

   // flags follow the count after this edge's transfers
   always_comb begin
      // storage handshake drops writes when full and reads when empty
      next_count = st_count + CNT_W'(wr_req && st_wr_ready) - CNT_W'(rd_req && st_rd_valid);
      // sixteen-bit offsets from the byte pairs
      empty_n_thr = {1'b0, empty_offset_high, empty_offset_low};
      full_m_thr = {1'b0, full_offset_high, full_offset_low};
      next_flags.empty_flag_n = (next_count != '0);
      next_flags.full_flag_n = (next_count != DEPTH_CNT);
      next_flags.almost_empty_flag_n = (THR_W'(next_count) > empty_n_thr);
      // low once count plus m reaches depth
      next_flags.almost_full_flag_n = ((THR_W'(next_count) + full_m_thr) < THR_W'(DEPTH_CNT));
   end

   // output register and drive enable
   always_comb begin
      next_read_data = read_data;
      // register holds on a read of an empty buffer
      if (rd_req && st_rd_valid) begin
         next_read_data = st_rd_data;
      end else if (ofs_rd) begin
         next_read_data = {1'b0, ofs_value};
      end
      // output enable low drives the bus
      next_read_oe = !i_output_enable_n;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         // empty condition; flags and zero data at once
         flags <= FLAGS_RST;
         read_data <= READ_DATA_RST;
         read_oe <= 1'b0;
      end else begin
         flags <= next_flags;
         read_data <= next_read_data;
         read_oe <= next_read_oe;
      end
   end

   always_comb begin
      o_flags = flags;
      o_read_data_bus = read_data;
      o_read_data_oe = read_oe;
   end
endmodule
`default_nettype wire

// [pfb_checker_assertions.sv]
// port checker for the programmable-flag buffer, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pfb_checker
   import pfb_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_write_enable_primary_n,
   input wire logic i_write_enable_secondary_or_load,
   input wire logic i_read_enable_a_n,
   input wire logic i_read_enable_b_n,
   input wire logic i_output_enable_n,
   input wire logic [DATA_W-1:0] o_read_data_bus,
   input wire logic o_read_data_oe,
   input wire pfb_flags_t o_flags
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   wire rd_req = !i_read_enable_a_n && !i_read_enable_b_n;
   sequence s_no_wr;
      i_write_enable_primary_n && i_write_enable_secondary_or_load;
   endsequence
   property p_oe;
      $past(i_arst_n) |-> o_read_data_oe == !$past(i_output_enable_n);
   endproperty
   a_oe: assert property (p_oe) else $error("oe not one cycle behind pin");
   property p_rst;
      $rose(i_arst_n) |-> o_flags == FLAGS_RST && o_read_data_bus == READ_DATA_RST;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state at reset release");
   property p_empty_hold;
      !o_flags.empty_flag_n ##0 s_no_wr |=> !o_flags.empty_flag_n && $stable(o_read_data_bus);
   endproperty
   a_empty_hold: assert property (p_empty_hold) else $error("empty changed unprompted");
   property p_full_hold;
      !o_flags.full_flag_n && !rd_req |=> !o_flags.full_flag_n;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full left without read");
   property p_af;
      !o_flags.full_flag_n |-> !o_flags.almost_full_flag_n;
   endproperty
   a_af: assert property (p_af) else $error("full but not almost full");
   property p_ae;
      !o_flags.empty_flag_n |-> !o_flags.almost_empty_flag_n;
   endproperty
   a_ae: assert property (p_ae) else $error("empty but not almost empty");
   property p_fill;
      $rose(o_flags.empty_flag_n) |-> !$past(i_write_enable_primary_n);
   endproperty
   a_fill: assert property (p_fill) else $error("left empty without write");
   property p_drain;
      $rose(o_flags.full_flag_n) |-> $past(rd_req);
   endproperty
   a_drain: assert property (p_drain) else $error("left full without read");
   property p_hold;
      i_read_enable_a_n && i_write_enable_secondary_or_load |=> $stable(o_read_data_bus);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule
bind pfb_top pfb_checker pfb_checker_inst (.i_clk_sys, .i_arst_n, .i_write_enable_primary_n,
   .i_write_enable_secondary_or_load, .i_read_enable_a_n, .i_read_enable_b_n,
   .i_output_enable_n, .o_read_data_bus, .o_read_data_oe, .o_flags);
`default_nettype wire

// [pfb_bus_model.sv]
// far-side model of the read data line behind the three-state driver
`timescale 1ns/1ps
`default_nettype none
module pfb_bus_model
   import pfb_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic [DATA_W-1:0] i_data,
   input wire logic i_oe,
   output logic [DATA_W-1:0] o_level
);
   logic [DATA_W-1:0] last;
   always_ff @(posedge i_clk_sys) begin
      if (i_oe) begin
         last <= i_data;
      end
   end
   // released line
   // no keeper, so a released line must never echo the old word
   assign o_level = i_oe ? i_data : ~last;
endmodule
`default_nettype wire

// [tb_pfb_top.sv]
// self-checking bench for the programmable-flag buffer
`timescale 1ns/1ps
`default_nettype none
module tb_pfb_top
   import pfb_pkg::*;
;
   logic i_clk_sys = 0, i_arst_n = 1, wp_n = 1, sec = 1, ra_n = 1, rb_n = 1, oe_n = 0;
   logic [DATA_W-1:0] wd = '0, q, lvl;
   logic q_oe;
   pfb_flags_t fl;
   int bad_count = 0, n_compared = 0, cyc = 0, k = 0;
   logic [DATA_W-1:0] ofs [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
   always #4 i_clk_sys = ~i_clk_sys;
   pfb_top pfb_top_inst (.i_clk_sys, .i_arst_n, .i_write_data_bus(wd),
      .i_write_enable_primary_n(wp_n), .i_write_enable_secondary_or_load(sec),
      .i_read_enable_a_n(ra_n), .i_read_enable_b_n(rb_n), .i_output_enable_n(oe_n),
      .o_read_data_bus(q), .o_read_data_oe(q_oe), .o_flags(fl));
   pfb_bus_model pfb_bus_model_inst (.i_clk_sys, .i_data(q), .i_oe(q_oe), .o_level(lvl));
   function automatic logic [DATA_W-1:0] pat(int i);
      return DATA_W'(i * 37 + 5);
   endfunction
   task automatic print_verdict();
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk_data(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_flags(string nm, pfb_flags_t e, pfb_flags_t g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_bit(string nm, logic e, logic g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic op(logic w, logic s, logic a, logic b, logic [DATA_W-1:0] d);
      @(negedge i_clk_sys);
      wp_n = w;
      sec = s;
      ra_n = a;
      rb_n = b;
      wd = d;
   endtask
   task automatic idle();
      op(1, 1, 1, 1, wd);
   endtask
   task automatic rd(logic [DATA_W-1:0] e, logic s);
      op(1, s, 0, 0, wd);
      @(posedge i_clk_sys);
      #1 chk_data("read", e, q);
   endtask
   task automatic fill(int c, pfb_flags_t f);
      while (k < c) begin
         op(0, 1, 1, 1, pat(k));
         k++;
      end
      idle();
      chk_flags("fill", f, fl);
   endtask
   // strap held through the first edge after release
   task automatic rst(logic strap);
      // a real falling edge, not a level left over from start-up
      i_arst_n = 0;
      op(1, strap, 1, 1, wd);
      repeat (20) @(negedge i_clk_sys);
      i_arst_n = 1;
      @(negedge i_clk_sys);
      k = 0;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      rst(1);
      chk_flags("reset flags", FLAGS_RST, fl);
      chk_data("reset data", READ_DATA_RST, q);
      rd(READ_DATA_RST, 1);
      op(0, 0, 1, 1, 9'h1aa);
      idle();
      chk_flags("no write", 4'b1100, fl);
      fill(7, 4'b1101);
      fill(8, 4'b1111);
      fill(56, 4'b1111);
      fill(57, 4'b1011);
      fill(64, 4'b0011);
      op(0, 1, 1, 1, 9'h0ff);
      op(1, 1, 0, 1, wd);
      idle();
      chk_flags("full", 4'b0011, fl);
      chk_data("one enable", READ_DATA_RST, q);
      for (int i = 0; i < 64; i++) rd(pat(i), 1);
      rd(pat(63), 1);
      idle();
      chk_flags("drained", 4'b1100, fl);
      oe_n = 1;
      idle();
      chk_bit("oe off", 1'b0, q_oe);
      chk_data("released", ~pat(63), lvl);
      oe_n = 0;
      idle();
      chk_bit("oe on", 1'b1, q_oe);
      chk_data("driven", pat(63), lvl);
      rst(0);
      chk_flags("reset again", FLAGS_RST, fl);
      op(0, 0, 1, 1, 9'h102);
      op(0, 0, 1, 1, 9'h000);
      idle();
      op(0, 0, 1, 1, 9'h003);
      op(0, 0, 1, 1, 9'h000);
      idle();
      // offset reads kept apart from loads
      foreach (ofs[j]) rd(ofs[j], 0);
      idle();
      fill(2, 4'b1101);
      fill(3, 4'b1111);
      fill(60, 4'b1111);
      fill(61, 4'b1011);
      // read and write in one cycle leave the level unchanged
      op(0, 1, 0, 0, 9'h155);
      @(posedge i_clk_sys);
      #1 chk_data("read during write", pat(0), q);
      idle();
      chk_flags("level kept", 4'b1011, fl);
      print_verdict();
   end
endmodule
`default_nettype wire
